// File: hw/sfwc_map.svh
`ifndef SFWC_MAP_SVH
`define SFWC_MAP_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SFWC_CTRL_OFF 8'h00
`define SFWC_ALEN_OFF 8'h04
`define SFWC_STAT_OFF 8'h08
`define SFWC_IEN_OFF 8'h0C
`define SFWC_ICLR_OFF 8'h10
`define SFWC_FSTATE_OFF 8'h14
`define SFWC_HDATA_OFF 8'h18
`define SFWC_HSEL_OFF 8'h1C
`define SFWC_HCNT_OFF 8'h20
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define SFWC_CTRL_SYNC 0
`define SFWC_CTRL_POL_LSB 1
`define SFWC_CTRL_AUTO_LSB 8
`define SFWC_CTRL_RST 32'h00000001
`define SFWC_ALEN_RST 16'h0040
`define SFWC_NUM_EV 5
`define SFWC_EV_AUTO 0
`define SFWC_EV_MANUAL 1
`define SFWC_EV_LOST 2
`define SFWC_EV_OVER 3
`define SFWC_EV_UNDER 4
// ----------------------------------------
// timing: idle access cycles added before pready
// ----------------------------------------
`define SFWC_APB_WAIT 1
`endif

// File: hw/sfwc_pkg.sv
`default_nettype none
package sfwc_pkg;
  // strobe order inside the polarity field
  typedef enum logic [2:0] {
    SFWC_POL_RD = 3'h0,
    SFWC_POL_WR = 3'h1,
    SFWC_POL_OE = 3'h2,
    SFWC_POL_CS = 3'h3,
    SFWC_POL_CM = 3'h4
  } sfwc_pol_t;
  typedef logic [1:0] sfwc_fifo_t;
endpackage : sfwc_pkg
`default_nettype wire

// File: hw/sfwc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sfwc_sync #(
  parameter int W = 1
) (
  input wire logic clk_in, // system clock
  input wire logic rst_in, // sync reset, high
  input wire logic [W-1:0] d_in, // asynchronous pins
  output logic [W-1:0] q_out // synchronised copy
);
  logic [W-1:0] meta;
  // ----------------------------------------
  // two-flop synchroniser
  // ----------------------------------------
  // first stage feeds only the second
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta <= '0;
      q_out <= '0;
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule : sfwc_sync
`default_nettype wire

// File: hw/sfwc_mem.sv
`timescale 1ns/1ps
`default_nettype none
module sfwc_mem #(
  parameter int DW = 16,
  parameter int AW = 10
) (
  input wire logic clk_in, // system clock
  input wire logic we_in, // write strobe
  input wire logic [AW-1:0] waddr_in, // write address
  input wire logic [DW-1:0] wdata_in, // write data
  input wire logic [AW-1:0] raddr_a_in, // link read address
  output logic [DW-1:0] rdata_a_out, // link read data, registered
  input wire logic [AW-1:0] raddr_b_in, // host read address
  output logic [DW-1:0] rdata_b_out // host read data, registered
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  // ----------------------------------------
  // one write port, two registered reads
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
    rdata_a_out <= mem[raddr_a_in];
    rdata_b_out <= mem[raddr_b_in];
  end
endmodule : sfwc_mem
`default_nettype wire

// File: hw/sfwc_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfwc_map.svh"
module sfwc_port #(
  parameter int DATA_W = 16,
  parameter int DEPTH = 256
) (
  input wire logic clk_in, // system clock, 100 MHz
  input wire logic rst_in, // sync reset, high
  input wire logic interface_clock_in, // link clock pin
  input wire logic fifo_read_strobe_in, // read strobe pin
  input wire logic fifo_write_strobe_in, // write strobe pin
  input wire logic fifo_drive_enable_in, // bus drive enable pin
  input wire logic port_select_in, // port select pin
  input wire logic packet_commit_strobe_in, // commit strobe pin
  input wire logic [1:0] fifo_select_in, // fifo select pins
  input wire logic [DATA_W-1:0] fifo_data_in, // data bus input
  output logic [DATA_W-1:0] fifo_data_out, // data bus output
  output logic fifo_data_oe_n_out, // low while driving the bus
  output logic fifo_empty_out, // selected fifo empty
  output logic fifo_full_out, // selected fifo full
  output logic irq_out, // level interrupt
  input wire logic psel_in, // apb select
  input wire logic penable_in, // apb enable
  input wire logic pwrite_in, // apb direction
  input wire logic [7:0] paddr_in, // apb byte address
  input wire logic [31:0] pwdata_in, // apb write data
  output logic [31:0] prdata_out, // apb read data
  output logic pready_out, // apb ready
  output logic pslverr_out // apb error
);
  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam int SW = 8 + DATA_W;
  if (DEPTH < 2 || (1 << AW) != DEPTH || DATA_W < 1 || DATA_W > 32 || PW > 16) begin : g_size_check
    $error("sfwc_port: DEPTH must be a power of two up to 32768, DATA_W 1..32");
  end
  // ----------------------------------------
  // pin synchronisation and edge finding
  // ----------------------------------------
  logic [SW-1:0] s;
  sfwc_sync #(.W(SW)) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in({interface_clock_in, fifo_read_strobe_in, fifo_write_strobe_in, fifo_drive_enable_in,
           port_select_in, packet_commit_strobe_in, fifo_select_in, fifo_data_in}),
    .q_out(s)
  );
  logic [31:0] ctrl, next_ctrl;
  logic [15:0] alen, next_alen;
  logic [4:0] pol;
  logic s_iclk, a_rd, a_wr, a_oe, a_cs, a_cm;
  logic [1:0] sel;
  logic [DATA_W-1:0] sdata;
  logic p_iclk, p_rd, p_wr, p_cm;
  logic sync_mode, iclk_rise, do_wr, do_rd, do_cm, live;
  logic [2:0] warm;
  // active levels follow the polarity field: 0 = active low
  always_comb begin
    pol = ctrl[`SFWC_CTRL_POL_LSB +: 5];
    s_iclk = s[SW-1];
    a_rd = s[SW-2] ~^ pol[sfwc_pkg::SFWC_POL_RD];
    a_wr = s[SW-3] ~^ pol[sfwc_pkg::SFWC_POL_WR];
    a_oe = s[SW-4] ~^ pol[sfwc_pkg::SFWC_POL_OE];
    a_cs = s[SW-5] ~^ pol[sfwc_pkg::SFWC_POL_CS];
    a_cm = s[SW-6] ~^ pol[sfwc_pkg::SFWC_POL_CM];
    sel = s[DATA_W +: 2];
    sdata = s[DATA_W-1:0];
    sync_mode = ctrl[`SFWC_CTRL_SYNC];
    iclk_rise = s_iclk & ~p_iclk;
    live = warm[2];
  end
  // sync mode acts on the link clock edge; async mode on strobe edges.
  // async writes take data at the trailing edge, where data setup is promised
  always_comb begin
    if (sync_mode) begin
      do_wr = live & iclk_rise & a_cs & a_wr;
      do_rd = live & iclk_rise & a_cs & a_rd;
      do_cm = live & iclk_rise & a_cs & a_cm;
    end else begin
      do_wr = live & a_cs & p_wr & ~a_wr;
      do_rd = live & a_cs & a_rd & ~p_rd;
      do_cm = live & a_cs & a_cm & ~p_cm;
    end
  end
  // previous active levels; warm masks the zeros that fill the sync pipeline after reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      p_iclk <= 1'b0;
      p_rd <= 1'b0;
      p_wr <= 1'b0;
      p_cm <= 1'b0;
      warm <= 3'h0;
    end else begin
      p_iclk <= s_iclk;
      p_rd <= a_rd;
      p_wr <= a_wr;
      p_cm <= a_cm;
      warm <= {warm[1:0], 1'b1};
    end
  end
  // ----------------------------------------
  // fifo pointers and commit counts
  // ----------------------------------------
  logic [PW-1:0] wp [4], rp [4], cmt [4];
  logic [PW-1:0] next_wp [4], next_rp [4], next_cmt [4];
  logic [3:0] empty, full;
  logic [`SFWC_NUM_EV-1:0] ev;
  logic [1:0] hsel, hw_sel, next_hw_sel, next_hsel;
  logic [DATA_W-1:0] hw_data, next_hw_data;
  logic hw_pend, next_hw_pend, host_pop, host_push, apb_done, mem_we;
  logic [AW+1:0] mem_waddr;
  logic [DATA_W-1:0] mem_wdata;
  logic [PW-1:0] cnt, unc;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      empty[i] = (wp[i] == rp[i]);
      full[i] = ((wp[i] - rp[i]) == PW'(DEPTH));
    end
  end
  // link traffic wins the write port; a host push waits in hw_pend
  always_comb begin
    next_wp = wp;
    next_rp = rp;
    next_cmt = cmt;
    ev = '0;
    mem_we = 1'b0;
    mem_waddr = {sel, wp[sel][AW-1:0]};
    mem_wdata = sdata;
    next_hw_pend = hw_pend;
    next_hw_sel = hw_sel;
    next_hw_data = hw_data;
    cnt = wp[sel] - rp[sel];
    unc = cnt - cmt[sel];
    if (do_wr) begin
      if (full[sel]) begin
        ev[`SFWC_EV_OVER] = 1'b1;
      end else begin
        mem_we = 1'b1;
        next_wp[sel] = wp[sel] + 1'b1;
        cnt = cnt + 1'b1;
        unc = unc + 1'b1;
      end
    end
    if (do_wr && !full[sel] && ctrl[`SFWC_CTRL_AUTO_LSB + sel] && (16'(unc) >= alen)) begin
      next_cmt[sel] = cnt;
      ev[`SFWC_EV_AUTO] = 1'b1;
      // a commit on the same edge as the auto commit is lost
      if (do_cm) begin
        ev[`SFWC_EV_LOST] = 1'b1;
      end
    end else if (do_cm) begin
      next_cmt[sel] = cnt;
      ev[`SFWC_EV_MANUAL] = 1'b1;
    end
    if (do_rd) begin
      if (empty[sel]) begin
        ev[`SFWC_EV_UNDER] = 1'b1;
      end else begin
        next_rp[sel] = rp[sel] + 1'b1;
        if (next_cmt[sel] != '0) begin // head words are the committed ones
          next_cmt[sel] = next_cmt[sel] - 1'b1;
        end
      end
    end
    if (host_pop) begin
      if (cmt[hsel] == '0 || (do_rd && sel == hsel)) begin
        ev[`SFWC_EV_UNDER] = 1'b1;
      end else begin
        next_rp[hsel] = rp[hsel] + 1'b1;
        next_cmt[hsel] = next_cmt[hsel] - 1'b1;
      end
    end
    if (hw_pend && !mem_we) begin
      next_hw_pend = 1'b0;
      if (full[hw_sel]) begin
        ev[`SFWC_EV_OVER] = 1'b1;
      end else begin
        mem_we = 1'b1;
        mem_waddr = {hw_sel, wp[hw_sel][AW-1:0]};
        mem_wdata = hw_data;
        next_wp[hw_sel] = wp[hw_sel] + 1'b1;
      end
    end
    if (host_push) begin
      next_hw_pend = 1'b1;
      next_hw_sel = hsel;
      next_hw_data = pwdata_in[DATA_W-1:0];
    end
  end
  // pointer, count and pending-push registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wp <= '{default: '0};
      rp <= '{default: '0};
      cmt <= '{default: '0};
      hw_pend <= 1'b0;
      hw_sel <= 2'h0;
      hw_data <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      cmt <= next_cmt;
      hw_pend <= next_hw_pend;
      hw_sel <= next_hw_sel;
      hw_data <= next_hw_data;
    end
  end
  // ----------------------------------------
  // storage: four fifos in one memory
  // ----------------------------------------
  logic [DATA_W-1:0] rd_a, rd_b;
  sfwc_mem #(.DW(DATA_W), .AW(AW + 2)) u_mem (
    .clk_in(clk_in),
    .we_in(mem_we),
    .waddr_in(mem_waddr),
    .wdata_in(mem_wdata),
    .raddr_a_in({sel, rp[sel][AW-1:0]}),
    .rdata_a_out(rd_a),
    .raddr_b_in({hsel, rp[hsel][AW-1:0]}),
    .rdata_b_out(rd_b)
  );
  // ----------------------------------------
  // link outputs
  // ----------------------------------------
  // prefetched word of the selected fifo, flags follow select alone
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fifo_data_out <= '0;
      fifo_data_oe_n_out <= 1'b1;
      fifo_empty_out <= 1'b1;
      fifo_full_out <= 1'b0;
    end else begin
      fifo_data_out <= rd_a;
      fifo_data_oe_n_out <= ~(a_oe & live);
      fifo_empty_out <= empty[sel];
      fifo_full_out <= full[sel];
    end
  end
  // ----------------------------------------
  // apb slave and registers
  // ----------------------------------------
  logic acc, next_acc, next_pready, next_pslverr, hit;
  logic [31:0] next_prdata, rmux;
  logic [`SFWC_NUM_EV-1:0] stat, ien, next_stat, next_ien;
  assign apb_done = psel_in & penable_in & pready_out;
  assign host_pop = apb_done & ~pwrite_in & (paddr_in == `SFWC_HDATA_OFF);
  assign host_push = apb_done & pwrite_in & (paddr_in == `SFWC_HDATA_OFF);
  // read mux; a miss answers with pslverr
  always_comb begin
    hit = 1'b1;
    rmux = 32'h00000000;
    unique case (paddr_in)
      `SFWC_CTRL_OFF: rmux = ctrl;
      `SFWC_ALEN_OFF: rmux = {16'h0000, alen};
      `SFWC_STAT_OFF: rmux[`SFWC_NUM_EV-1:0] = stat;
      `SFWC_IEN_OFF: rmux[`SFWC_NUM_EV-1:0] = ien;
      `SFWC_ICLR_OFF: rmux = 32'h00000000;
      `SFWC_FSTATE_OFF: rmux[7:0] = {full, empty};
      `SFWC_HDATA_OFF: rmux[DATA_W-1:0] = rd_b;
      `SFWC_HSEL_OFF: rmux[1:0] = hsel;
      `SFWC_HCNT_OFF: rmux[PW-1:0] = cmt[hsel];
      default: hit = 1'b0;
    endcase
  end
  // one idle access cycle lets the host read port settle
  always_comb begin
    next_acc = acc;
    next_pready = 1'b0;
    next_prdata = prdata_out;
    next_pslverr = 1'b0;
    if (psel_in && penable_in && !pready_out) begin
      if (!acc) begin
        next_acc = 1'b1;
      end else begin
        next_acc = 1'b0;
        next_pready = 1'b1;
        next_prdata = pwrite_in ? 32'h00000000 : rmux;
        next_pslverr = ~hit;
      end
    end
    next_ctrl = ctrl;
    next_alen = alen;
    next_ien = ien;
    next_hsel = hsel;
    next_stat = stat | ev;
    if (apb_done && pwrite_in) begin
      unique case (paddr_in)
        `SFWC_CTRL_OFF: next_ctrl = {20'h00000, pwdata_in[11:8], 2'b00, pwdata_in[5:0]};
        `SFWC_ALEN_OFF: next_alen = pwdata_in[15:0];
        `SFWC_IEN_OFF: next_ien = pwdata_in[`SFWC_NUM_EV-1:0];
        `SFWC_ICLR_OFF: next_stat = (stat & ~pwdata_in[`SFWC_NUM_EV-1:0]) | ev; // set wins
        `SFWC_HSEL_OFF: next_hsel = pwdata_in[1:0];
        default: next_hsel = hsel;
      endcase
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      acc <= 1'b0;
      pready_out <= 1'b0;
      prdata_out <= 32'h00000000;
      pslverr_out <= 1'b0;
      ctrl <= `SFWC_CTRL_RST;
      alen <= `SFWC_ALEN_RST;
      ien <= '0;
      stat <= '0;
      hsel <= 2'h0;
      irq_out <= 1'b0;
    end else begin
      acc <= next_acc;
      pready_out <= next_pready;
      prdata_out <= next_prdata;
      pslverr_out <= next_pslverr;
      ctrl <= next_ctrl;
      alen <= next_alen;
      ien <= next_ien;
      stat <= next_stat;
      hsel <= next_hsel;
      irq_out <= |(stat & ien);
    end
  end
endmodule : sfwc_port
`default_nettype wire

// File: bench/sfwc_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sfwc_port_monitor (
  input wire logic clk_in, // system clock
  input wire logic rst_in, // sync reset, high
  input wire logic fifo_read_strobe_in, // read strobe pin
  input wire logic fifo_write_strobe_in, // write strobe pin
  input wire logic fifo_drive_enable_in, // drive enable pin
  input wire logic packet_commit_strobe_in, // commit strobe pin
  input wire logic [1:0] fifo_select_in, // fifo select pins
  input wire logic fifo_data_oe_n_out, // bus drive, low active
  input wire logic fifo_empty_out, // empty flag
  input wire logic fifo_full_out, // full flag
  input wire logic psel_in, // apb select
  input wire logic penable_in, // apb enable
  input wire logic pready_out, // apb ready
  input wire logic pslverr_out // apb error
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ----------------------------------------
  // named steps
  // ----------------------------------------
  sequence s_setup;
    psel_in && !penable_in ##1 psel_in && penable_in;
  endsequence
  sequence s_answer;
    !pready_out ##1 !pready_out ##1 pready_out;
  endsequence
  // quiet pins: strobes idle (active low) and no host access
  sequence s_idle;
    (fifo_write_strobe_in && fifo_read_strobe_in && packet_commit_strobe_in && !psel_in
     && $stable(fifo_select_in)) [*6];
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_ready_third_cycle: assert property (s_setup |-> s_answer)
    else $error("pready not in third access cycle");
  a_ready_one_pulse: assert property (pready_out |=> !pready_out)
    else $error("pready held too long");
  a_ready_in_access: assert property (pready_out |-> psel_in && penable_in)
    else $error("pready outside access phase");
  a_err_with_ready: assert property (pslverr_out |-> pready_out)
    else $error("pslverr without pready");
  a_bus_drive_on: assert property (!fifo_drive_enable_in [*5] |-> !fifo_data_oe_n_out)
    else $error("bus not driven while enabled");
  a_bus_drive_off: assert property (fifo_drive_enable_in [*5] |-> fifo_data_oe_n_out)
    else $error("bus driven while disabled");
  a_flags_exclusive: assert property (!(fifo_empty_out && fifo_full_out))
    else $error("empty and full together");
  a_flags_quiet: assert property (s_idle |-> $stable(fifo_empty_out) && $stable(fifo_full_out))
    else $error("flags moved without strobe");
endmodule : sfwc_port_monitor
bind sfwc_port sfwc_port_monitor u_mon (
  .clk_in(clk_in), .rst_in(rst_in), .fifo_read_strobe_in(fifo_read_strobe_in),
  .fifo_write_strobe_in(fifo_write_strobe_in), .fifo_drive_enable_in(fifo_drive_enable_in),
  .packet_commit_strobe_in(packet_commit_strobe_in), .fifo_select_in(fifo_select_in),
  .fifo_data_oe_n_out(fifo_data_oe_n_out), .fifo_empty_out(fifo_empty_out), .fifo_full_out(fifo_full_out),
  .psel_in(psel_in), .penable_in(penable_in), .pready_out(pready_out), .pslverr_out(pslverr_out)
);
`default_nettype wire

// File: bench/sfwc_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module sfwc_master_model (
  input wire logic clk_in, // bench clock, pacing only
  output logic iclk_out, // link clock, still between frames
  output logic wr_n_out, // write strobe, low active
  output logic rd_n_out, // read strobe, low active
  output logic cm_n_out, // commit strobe, low active
  output logic cs_n_out, // port select, low active
  output logic [15:0] data_out // write data
);
  // ----------------------------------------
  // idle pins
  // ----------------------------------------
  initial begin
    iclk_out = 1'b0;
    wr_n_out = 1'b1;
    rd_n_out = 1'b1;
    cm_n_out = 1'b1;
    cs_n_out = 1'b1;
    data_out = 16'h0000;
  end
  // one link frame: 80 ns clock pulse in sync mode, 160 ns strobe pulse in async mode
  task automatic xfer(input logic sync, input logic w, input logic r, input logic c, input logic [15:0] d);
    data_out <= d;
    cs_n_out <= 1'b0; // select ahead of any strobe
    @(posedge clk_in);
    wr_n_out <= ~w;
    rd_n_out <= ~r;
    cm_n_out <= ~c; // commit may ride with the last word in sync mode only, or come later
    repeat (8) @(posedge clk_in);
    iclk_out <= sync;
    repeat (8) @(posedge clk_in);
    iclk_out <= 1'b0;
    wr_n_out <= 1'b1;
    rd_n_out <= 1'b1;
    cm_n_out <= 1'b1;
    repeat (8) @(posedge clk_in);
    data_out <= ~d; // released bus must not keep the old word
    cs_n_out <= 1'b1;
    @(posedge clk_in);
  endtask : xfer
endmodule : sfwc_master_model
`default_nettype wire

// File: bench/sfwc_port_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfwc_map.svh"
module sfwc_port_test;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h00000000;
  logic drive_n = 1'b1;
  logic [1:0] fsel = 2'h0;
  logic iclk, wr_n, rd_n, cm_n, cs_n, oe_n, empty, full, irq, pready, pslverr, err_seen;
  logic [15:0] mdata, rdata;
  logic [31:0] prdata;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  // ----------------------------------------
  // clock, design and far side
  // ----------------------------------------
  always #5 clk_in = ~clk_in;
  sfwc_port #(.DATA_W(16), .DEPTH(256)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .interface_clock_in(iclk), .fifo_read_strobe_in(rd_n),
    .fifo_write_strobe_in(wr_n), .fifo_drive_enable_in(drive_n), .port_select_in(cs_n),
    .packet_commit_strobe_in(cm_n), .fifo_select_in(fsel), .fifo_data_in(mdata), .fifo_data_out(rdata),
    .fifo_data_oe_n_out(oe_n), .fifo_empty_out(empty), .fifo_full_out(full), .irq_out(irq),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr)
  );
  sfwc_master_model u_master (
    .clk_in(clk_in), .iclk_out(iclk), .wr_n_out(wr_n), .rd_n_out(rd_n), .cm_n_out(cm_n),
    .cs_n_out(cs_n), .data_out(mdata)
  );
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask : chk
  // apb master: waits for pready with no assumed latency
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    r = prdata;
    err_seen = pslverr;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    apb(1'b0, a, 32'h00000000, r);
    chk(r, exp);
  endtask : rdc
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  // hang guard, far above the roughly 500 cycles needed
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    // the bus must stay released while the pin pipeline refills
    repeat (3) begin
      @(posedge clk_in);
      chk({31'h0, oe_n}, 32'h00000001);
    end
    rdc(`SFWC_CTRL_OFF, 32'h00000001);
    rdc(`SFWC_ALEN_OFF, 32'h00000040);
    rdc(`SFWC_FSTATE_OFF, 32'h0000000F);
    rdc(8'h24, 32'h00000000);
    chk({31'h0, err_seen}, 32'h00000001);
    $display("test reset done");
    fsel <= 2'h1;
    u_master.xfer(1'b1, 1'b1, 1'b0, 1'b0, 16'h1234);
    u_master.xfer(1'b1, 1'b1, 1'b0, 1'b1, 16'h5678);
    u_master.xfer(1'b1, 1'b1, 1'b0, 1'b0, 16'h9ABC);
    u_master.xfer(1'b1, 1'b0, 1'b0, 1'b1, 16'h0000);
    wr(`SFWC_HSEL_OFF, 32'h00000001);
    rdc(`SFWC_HCNT_OFF, 32'h00000003);
    rdc(`SFWC_STAT_OFF, 32'h00000002);
    fsel <= 2'h2;
    repeat (8) @(posedge clk_in);
    chk({31'h0, empty}, 32'h00000001);
    fsel <= 2'h1;
    repeat (8) @(posedge clk_in);
    chk({31'h0, empty}, 32'h00000000);
    $display("test manual commit done");
    drive_n <= 1'b0;
    repeat (8) @(posedge clk_in);
    chk({31'h0, oe_n}, 32'h00000000);
    chk({16'h0, rdata}, 32'h00001234);
    u_master.xfer(1'b1, 1'b0, 1'b1, 1'b0, 16'h0000);
    chk({16'h0, rdata}, 32'h00005678);
    drive_n <= 1'b1;
    repeat (8) @(posedge clk_in);
    chk({31'h0, oe_n}, 32'h00000001);
    rdc(`SFWC_HDATA_OFF, 32'h00005678);
    rdc(`SFWC_HCNT_OFF, 32'h00000001);
    $display("test read done");
    wr(`SFWC_ICLR_OFF, 32'h0000001F);
    wr(`SFWC_ALEN_OFF, 32'h00000002);
    wr(`SFWC_CTRL_OFF, 32'h00000C01);
    wr(`SFWC_IEN_OFF, 32'h00000004);
    fsel <= 2'h3;
    u_master.xfer(1'b1, 1'b1, 1'b0, 1'b0, 16'h0011);
    u_master.xfer(1'b1, 1'b1, 1'b0, 1'b0, 16'h0022);
    u_master.xfer(1'b1, 1'b1, 1'b0, 1'b1, 16'h0033);
    wr(`SFWC_HSEL_OFF, 32'h00000003);
    rdc(`SFWC_HCNT_OFF, 32'h00000003);
    rdc(`SFWC_STAT_OFF, 32'h00000003);
    chk({31'h0, irq}, 32'h00000000);
    wr(`SFWC_ICLR_OFF, 32'h0000001F);
    fsel <= 2'h2;
    u_master.xfer(1'b1, 1'b1, 1'b0, 1'b0, 16'h0044);
    u_master.xfer(1'b1, 1'b1, 1'b0, 1'b1, 16'h0055);
    wr(`SFWC_HSEL_OFF, 32'h00000002);
    rdc(`SFWC_HCNT_OFF, 32'h00000002);
    rdc(`SFWC_STAT_OFF, 32'h00000005);
    repeat (2) @(posedge clk_in);
    chk({31'h0, irq}, 32'h00000001);
    wr(`SFWC_IEN_OFF, 32'h00000000);
    repeat (2) @(posedge clk_in);
    chk({31'h0, irq}, 32'h00000000);
    wr(`SFWC_IEN_OFF, 32'h00000004);
    repeat (2) @(posedge clk_in);
    chk({31'h0, irq}, 32'h00000001);
    wr(`SFWC_ICLR_OFF, 32'h00000004);
    repeat (2) @(posedge clk_in);
    chk({31'h0, irq}, 32'h00000000);
    $display("test auto commit done");
    wr(`SFWC_CTRL_OFF, 32'h00000000);
    fsel <= 2'h0;
    u_master.xfer(1'b0, 1'b1, 1'b0, 1'b0, 16'hA55A);
    u_master.xfer(1'b0, 1'b0, 1'b0, 1'b1, 16'h0000);
    wr(`SFWC_HSEL_OFF, 32'h00000000);
    rdc(`SFWC_HCNT_OFF, 32'h00000001);
    rdc(`SFWC_HDATA_OFF, 32'h0000A55A);
    $display("test async done");
    stop_test();
  end
endmodule : sfwc_port_test
`default_nettype wire
